// file: rtl/rrs_regs.svh
`ifndef RRS_REGS_SVH
`define RRS_REGS_SVH
// Register byte offsets
`define RRS_OFF_CRC 12'h400
`define RRS_OFF_LADDR 12'h408
`define RRS_OFF_CRC_VAL 12'h40c
`define RRS_OFF_MATCH_IDX 12'h410
`define RRS_OFF_PDU 12'h414
`define RRS_OFF_CTE 12'h44c
`define RRS_OFF_DFE 12'h458
`define RRS_OFF_PTR 12'h504
`define RRS_OFF_CHAN 12'h508
`define RRS_OFF_IRQ_STAT 12'h600
`define RRS_OFF_IRQ_MASK 12'h604
// Reset values
`define RRS_RST_ZERO 32'h0000_0000
`define RRS_RST_CHAN_OFS 7'h02
`define RRS_RST_CHAN_MAP 1'h0
// Channel select fields
`define RRS_CHAN_OFS_MSB 6
`define RRS_CHAN_MAP_BIT 8
// Tone extension info fields
`define RRS_CTE_TIME_MSB 4
`define RRS_CTE_RSV_BIT 5
`define RRS_CTE_TYPE_LSB 6
`define RRS_CTE_TYPE_MSB 7
// Direction finding state fields
`define RRS_DFE_SW_MSB 2
`define RRS_DFE_SAMP_BIT 4
// Carrier bases in MHz
`define RRS_BASE_DEFAULT 12'h960
`define RRS_BASE_LOW 12'h938
// Antenna switching phase lengths in cycles
`define RRS_LEN_OFFSET 8'h04
`define RRS_LEN_GUARD 8'h08
`define RRS_LEN_REF 8'h10
`define RRS_LEN_SWITCH 8'h20
`define RRS_LEN_END 8'h02
// Interrupt bits
`define RRS_IRQ_RXEND 0
`define RRS_IRQ_CRCERR 1
`define RRS_IRQ_DFEEND 2
`define RRS_IRQ_W 3
`endif

// file: rtl/rrs_pkg.sv
package rrs_pkg;
  // Per-packet status from the receiver
  typedef struct packed {
    logic crc_ok;
    logic [2:0] logical_addr;
    logic [23:0] crc_value;
    logic [2:0] match_index;
    logic [2:0] payload_status;
    logic [7:0] cte_info;
  } rrs_rx_status_t;
  // Antenna switching states, coded 0 to 5
  typedef enum logic [2:0] {
    RRS_SW_IDLE,
    RRS_SW_OFFSET,
    RRS_SW_GUARD,
    RRS_SW_REF,
    RRS_SW_SWITCHING,
    RRS_SW_ENDING
  } rrs_sw_state_t;
  // Sampler states, coded 0 and 1
  typedef enum logic {
    RRS_SAMP_IDLE,
    RRS_SAMP_ACTIVE
  } rrs_samp_state_t;
  // DMA request towards packet RAM
  typedef struct packed {
    logic [31:0] addr;
    logic to_ram;
  } rrs_dma_req_t;
endpackage

// file: rtl/rrs_top.sv
// Our own choice: the APB interface to the registers.
`include "rrs_regs.svh"
module rrs_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Receiver status
  input wire logic rx_done,
  input wire rrs_pkg::rrs_rx_status_t rx_status,
  // Packet transfer starts
  input wire logic tx_start,
  input wire logic rx_start,
  // Direction finding start
  input wire logic dfe_start,
  // Radio outputs
  output rrs_pkg::rrs_dma_req_t dma_req,
  output logic dma_req_valid,
  output logic [11:0] rf_freq_mhz,
  output logic antenna_switch_en,
  output logic sampler_en,
  // Interrupt
  output logic irq
);

  // Register state
  rrs_pkg::rrs_rx_status_t rx_stat_ff;
  logic [31:0] pkt_ptr_ff;
  logic [6:0] chan_ofs_ff;
  logic chan_map_ff;
  logic [`RRS_IRQ_W-1:0] irq_stat_ff;
  logic [`RRS_IRQ_W-1:0] irq_mask_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;
  rrs_pkg::rrs_dma_req_t dma_req_ff;
  logic dma_valid_ff;
  logic [11:0] freq_ff;
  rrs_pkg::rrs_sw_state_t sw_state_ff;
  rrs_pkg::rrs_sw_state_t nxt_sw_state;
  rrs_pkg::rrs_samp_state_t samp_state_ff;
  logic [7:0] sw_cnt_ff;
  logic [7:0] nxt_sw_cnt;
  logic dfe_end_ff;

  // Bus phase decode
  logic setup_ph;
  logic access_ph;
  logic wr_en;
  logic [11:0] ofs;
  logic [31:0] rd_val;
  logic rd_hit;
  logic [7:0] phase_len;
  logic [`RRS_IRQ_W-1:0] irq_events;
  logic [`RRS_IRQ_W-1:0] irq_w1c;

  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign wr_en = access_ph && pwrite;
  assign ofs = paddr[11:0];

  // Zero wait state answer
  assign pready = 1'b1;
  assign prdata = prdata_ff;
  assign pslverr = pslverr_ff && access_ph;

  // Read mux
  always_comb
  begin
    rd_val = `RRS_RST_ZERO;
    rd_hit = 1'b1;
    case (ofs)
      `RRS_OFF_CRC:
        rd_val[0] = rx_stat_ff.crc_ok;
      `RRS_OFF_LADDR:
        rd_val[2:0] = rx_stat_ff.logical_addr;
      `RRS_OFF_CRC_VAL:
        rd_val[23:0] = rx_stat_ff.crc_value;
      `RRS_OFF_MATCH_IDX:
        rd_val[2:0] = rx_stat_ff.match_index;
      `RRS_OFF_PDU:
        rd_val[2:0] = rx_stat_ff.payload_status;
      `RRS_OFF_CTE:
      begin
        rd_val[`RRS_CTE_TIME_MSB:0] = rx_stat_ff.cte_info[`RRS_CTE_TIME_MSB:0];
        rd_val[`RRS_CTE_RSV_BIT] = rx_stat_ff.cte_info[`RRS_CTE_RSV_BIT];
        rd_val[`RRS_CTE_TYPE_MSB:`RRS_CTE_TYPE_LSB] =
          rx_stat_ff.cte_info[`RRS_CTE_TYPE_MSB:`RRS_CTE_TYPE_LSB];
      end
      `RRS_OFF_DFE:
      begin
        rd_val[`RRS_DFE_SW_MSB:0] = sw_state_ff;
        rd_val[`RRS_DFE_SAMP_BIT] = samp_state_ff;
      end
      `RRS_OFF_PTR:
        rd_val = pkt_ptr_ff;
      `RRS_OFF_CHAN:
      begin
        rd_val[`RRS_CHAN_OFS_MSB:0] = chan_ofs_ff;
        rd_val[`RRS_CHAN_MAP_BIT] = chan_map_ff;
      end
      `RRS_OFF_IRQ_STAT:
        rd_val[`RRS_IRQ_W-1:0] = irq_stat_ff;
      `RRS_OFF_IRQ_MASK:
        rd_val[`RRS_IRQ_W-1:0] = irq_mask_ff;
      default:
        rd_hit = 1'b0;
    endcase
  end

  // Read data and error captured in setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_ff <= `RRS_RST_ZERO;
      pslverr_ff <= 1'b0;
    end
    else if (setup_ph)
    begin
      prdata_ff <= pwrite ? `RRS_RST_ZERO : rd_val;
      pslverr_ff <= !rd_hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rx_stat_ff <= '0;
    else if (rx_done)
      rx_stat_ff <= rx_status;
  end

  // Packet pointer, any byte address kept as written
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pkt_ptr_ff <= `RRS_RST_ZERO;
    else if (wr_en && ofs == `RRS_OFF_PTR)
      pkt_ptr_ff <= pwdata;
  end

  // Channel select register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      chan_ofs_ff <= `RRS_RST_CHAN_OFS;
      chan_map_ff <= `RRS_RST_CHAN_MAP;
    end
    else if (wr_en && ofs == `RRS_OFF_CHAN)
    begin
      chan_ofs_ff <= pwdata[`RRS_CHAN_OFS_MSB:0];
      chan_map_ff <= pwdata[`RRS_CHAN_MAP_BIT];
    end
  end

  // Carrier frequency from map and offset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      freq_ff <= `RRS_BASE_DEFAULT;
    else if (chan_map_ff)
      freq_ff <= `RRS_BASE_LOW + {5'h00, chan_ofs_ff};
    else
      freq_ff <= `RRS_BASE_DEFAULT + {5'h00, chan_ofs_ff};
  end

  assign rf_freq_mhz = freq_ff;

  // pointer handed to DMA at start
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dma_req_ff <= '0;
      dma_valid_ff <= 1'b0;
    end
    else if (tx_start || rx_start)
    begin
      dma_req_ff.addr <= pkt_ptr_ff;
      dma_req_ff.to_ram <= rx_start;
      dma_valid_ff <= 1'b1;
    end
    else if (rx_done)
      dma_valid_ff <= 1'b0;
  end

  assign dma_req = dma_req_ff;
  assign dma_req_valid = dma_valid_ff;

  // Length of the current switching phase
  always_comb
  begin
    case (sw_state_ff)
      rrs_pkg::RRS_SW_OFFSET:
        phase_len = `RRS_LEN_OFFSET;
      rrs_pkg::RRS_SW_GUARD:
        phase_len = `RRS_LEN_GUARD;
      rrs_pkg::RRS_SW_REF:
        phase_len = `RRS_LEN_REF;
      rrs_pkg::RRS_SW_SWITCHING:
        phase_len = `RRS_LEN_SWITCH;
      rrs_pkg::RRS_SW_ENDING:
        phase_len = `RRS_LEN_END;
      default:
        phase_len = 8'h01;
    endcase
  end

  // Switching state sequence
  always_comb
  begin
    nxt_sw_state = sw_state_ff;
    nxt_sw_cnt = sw_cnt_ff + 8'h01;
    case (sw_state_ff)
      rrs_pkg::RRS_SW_IDLE:
      begin
        nxt_sw_cnt = 8'h00;
        if (dfe_start)
          nxt_sw_state = rrs_pkg::RRS_SW_OFFSET;
      end
      rrs_pkg::RRS_SW_OFFSET:
        if (nxt_sw_cnt == phase_len)
          nxt_sw_state = rrs_pkg::RRS_SW_GUARD;
      rrs_pkg::RRS_SW_GUARD:
        if (nxt_sw_cnt == phase_len)
          nxt_sw_state = rrs_pkg::RRS_SW_REF;
      rrs_pkg::RRS_SW_REF:
        if (nxt_sw_cnt == phase_len)
          nxt_sw_state = rrs_pkg::RRS_SW_SWITCHING;
      rrs_pkg::RRS_SW_SWITCHING:
        if (nxt_sw_cnt == phase_len)
          nxt_sw_state = rrs_pkg::RRS_SW_ENDING;
      rrs_pkg::RRS_SW_ENDING:
        if (nxt_sw_cnt == phase_len)
          nxt_sw_state = rrs_pkg::RRS_SW_IDLE;
      default:
        nxt_sw_state = rrs_pkg::RRS_SW_IDLE;
    endcase
    if (nxt_sw_state != sw_state_ff)
      nxt_sw_cnt = 8'h00;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sw_state_ff <= rrs_pkg::RRS_SW_IDLE;
      sw_cnt_ff <= 8'h00;
    end
    else
    begin
      sw_state_ff <= nxt_sw_state;
      sw_cnt_ff <= nxt_sw_cnt;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      samp_state_ff <= rrs_pkg::RRS_SAMP_IDLE;
    else if (nxt_sw_state == rrs_pkg::RRS_SW_REF ||
             nxt_sw_state == rrs_pkg::RRS_SW_SWITCHING)
      samp_state_ff <= rrs_pkg::RRS_SAMP_ACTIVE;
    else
      samp_state_ff <= rrs_pkg::RRS_SAMP_IDLE;
  end

  assign antenna_switch_en = (sw_state_ff != rrs_pkg::RRS_SW_IDLE);
  assign sampler_en = (samp_state_ff == rrs_pkg::RRS_SAMP_ACTIVE);

  // End of a direction finding run
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dfe_end_ff <= 1'b0;
    else
      dfe_end_ff <= (sw_state_ff == rrs_pkg::RRS_SW_ENDING) &&
                    (nxt_sw_state == rrs_pkg::RRS_SW_IDLE);
  end

  // Interrupt events and write-one-to-clear
  always_comb
  begin
    irq_events = '0;
    irq_events[`RRS_IRQ_RXEND] = rx_done;
    irq_events[`RRS_IRQ_CRCERR] = rx_done && !rx_status.crc_ok;
    irq_events[`RRS_IRQ_DFEEND] = dfe_end_ff;
    irq_w1c = '0;
    if (wr_en && ofs == `RRS_OFF_IRQ_STAT)
      irq_w1c = pwdata[`RRS_IRQ_W-1:0];
  end

  // Sticky status, set wins over clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_stat_ff <= '0;
    else
      irq_stat_ff <= (irq_stat_ff & ~irq_w1c) | irq_events;
  end

  // Interrupt mask register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_mask_ff <= '0;
    else if (wr_en && ofs == `RRS_OFF_IRQ_MASK)
      irq_mask_ff <= pwdata[`RRS_IRQ_W-1:0];
  end

  // Level interrupt
  assign irq = |(irq_stat_ff & irq_mask_ff);

endmodule

// file: sim/rrs_checker.sv
module rrs_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  // Radio
  input wire logic tx_start,
  input wire logic rx_start,
  input wire logic rx_done,
  input wire logic dfe_start,
  input wire rrs_pkg::rrs_dma_req_t dma_req,
  input wire logic dma_req_valid,
  input wire logic [11:0] rf_freq_mhz,
  input wire logic antenna_switch_en,
  input wire logic sampler_en
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] run_ff;
  logic dfe_start_idle;
  logic [7:0] samp_ff;
  logic acc;
  logic known;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Access phase and decoded offset
  assign acc = psel && penable;
  // Start request seen while the switching run is idle
  assign dfe_start_idle = dfe_start && !antenna_switch_en;
  assign known = paddr[11:0] inside {12'h400, 12'h408, 12'h40c, 12'h410, 12'h414,
    12'h44c, 12'h458, 12'h504, 12'h508, 12'h600, 12'h604};
  // Lengths of the switching run and of sampling
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_ff <= 8'h00;
      samp_ff <= 8'h00;
    end
    else
    begin
      run_ff <= antenna_switch_en ? run_ff + 8'h01 : 8'h00;
      samp_ff <= sampler_en ? samp_ff + 8'h01 : 8'h00;
    end
  end
  // Steps of a direction-finding run
  sequence s_lead;
    (antenna_switch_en && !sampler_en)[*8] ##1 (antenna_switch_en && !sampler_en)[*4];
  endsequence
  sequence s_sample;
    antenna_switch_en && sampler_en;
  endsequence
  property p_rf;
    acc && pwrite && paddr[11:0] == 12'h508 |-> ##2
      rf_freq_mhz == ($past(pwdata[8], 2) ? 12'h938 : 12'h960) + $past(pwdata[6:0], 2);
  endproperty
  property p_err;
    1'b1 |-> pslverr == (acc && !known);
  endproperty
  property p_dma_rx;
    rx_start |=> dma_req_valid && dma_req.to_ram;
  endproperty
  property p_dma_tx;
    tx_start && !rx_start |=> dma_req_valid && !dma_req.to_ram;
  endproperty
  property p_dma_clr;
    rx_done && !tx_start && !rx_start |=> !dma_req_valid;
  endproperty
  property p_lead;
    dfe_start_idle |=> s_lead ##1 s_sample;
  endproperty
  property p_run;
    $fell(antenna_switch_en) |-> run_ff == 8'h3e;
  endproperty
  property p_samp;
    $fell(sampler_en) |-> samp_ff == 8'h30 && $past(antenna_switch_en);
  endproperty
  a_rf: assert property (p_rf) else $error("carrier wrong after channel write");
  a_err: assert property (p_err) else $error("error response wrong");
  a_dma_rx: assert property (p_dma_rx) else $error("receive request wrong");
  a_dma_tx: assert property (p_dma_tx) else $error("transmit request wrong");
  a_dma_clr: assert property (p_dma_clr) else $error("request not ended");
  a_lead: assert property (p_lead) else $error("run lead-in wrong");
  a_run: assert property (p_run) else $error("run length wrong");
  a_samp: assert property (p_samp) else $error("sampling length wrong");
endmodule

// file: sim/tb_rrs_top.sv
module tb_rrs_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd_data;
  logic pready, pslverr, dma_req_valid, antenna_switch_en, sampler_en, irq, err_seen;
  logic rx_done = 1'b0, tx_start = 1'b0, rx_start = 1'b0, dfe_start = 1'b0;
  logic [11:0] rf_freq_mhz;
  logic [11:0] offs [10] = '{12'h400, 12'h408, 12'h40c, 12'h410, 12'h414, 12'h44c,
    12'h458, 12'h504, 12'h600, 12'h604};
  logic [31:0] chans [4] = '{32'h0, 32'h64, 32'h100, 32'h164};
  rrs_pkg::rrs_rx_status_t rx_status = '0, s1, s2;
  rrs_pkg::rrs_dma_req_t dma_req;
  int failures = 0, compares = 0, hi, sp;
  // Clock
  always #5 pclk = ~pclk;
  rrs_top rrs_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_done(rx_done), .rx_status(rx_status), .tx_start(tx_start),
    .rx_start(rx_start), .dfe_start(dfe_start), .dma_req(dma_req),
    .dma_req_valid(dma_req_valid), .rf_freq_mhz(rf_freq_mhz),
    .antenna_switch_en(antenna_switch_en), .sampler_en(sampler_en), .irq(irq));
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic close_out;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // One bus transfer, setup then access until ready
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {20'h0, a};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
    begin
      failures++;
      close_out();
    end
    rd_data = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string name);
    apb(a, 1'b0, 32'h0);
    chk(name, exp, rd_data);
  endtask
  task automatic pkt(input rrs_pkg::rrs_rx_status_t s);
    rx_status <= s;
    rx_done <= 1'b1;
    @(posedge pclk);
    rx_done <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic chk_pkt(input rrs_pkg::rrs_rx_status_t s);
    rd(12'h400, {31'h0, s.crc_ok}, "crc result");
    rd(12'h408, {29'h0, s.logical_addr}, "logical address");
    rd(12'h40c, {8'h0, s.crc_value}, "crc value");
    rd(12'h410, {29'h0, s.match_index}, "match index");
    rd(12'h414, {29'h0, s.payload_status}, "payload status");
    rd(12'h44c, {24'h0, s.cte_info}, "tone info");
  endtask
  task automatic dfe_go;
    dfe_start <= 1'b1;
    @(posedge pclk);
    dfe_start <= 1'b0;
  endtask
  // Overall limit
  initial
  begin
    repeat (20000) @(posedge pclk);
    failures++;
    close_out();
  end
  // Main sequence
  initial
  begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (offs[i]) rd(offs[i], 32'h0, "reset value");
    rd(12'h508, 32'h2, "channel reset");
    chk("carrier", 32'h962, {20'h0, rf_freq_mhz});
    $display("test reset done");
    s1 = {1'h0, 3'h5, 24'habcdef, 3'h6, 3'h3, 8'hb7};
    s2 = {1'h1, 3'h2, 24'h123456, 3'h1, 3'h4, 8'h48};
    pkt(s1);
    chk_pkt(s1);
    wr(12'h408, 32'hffffffff);
    rx_status <= '1;
    chk_pkt(s1);
    rd(12'h600, 32'h3, "event status");
    chk("irq", 32'h0, {31'h0, irq});
    wr(12'h604, 32'h2);
    chk("irq", 32'h1, {31'h0, irq});
    wr(12'h600, 32'h2);
    rd(12'h600, 32'h1, "event status");
    chk("irq", 32'h0, {31'h0, irq});
    pkt(s2);
    chk_pkt(s2);
    wr(12'h600, 32'h1);
    rd(12'h600, 32'h0, "event status");
    $display("test packets done");
    foreach (chans[i])
    begin
      wr(12'h508, chans[i]);
      rd(12'h508, chans[i], "channel");
      chk("carrier", {20'h0, (chans[i][8] ? 12'h938 : 12'h960) + chans[i][6:0]}, 
        {20'h0, rf_freq_mhz});
    end
    $display("test channel done");
    wr(12'h504, 32'h20000003);
    rd(12'h504, 32'h20000003, "pointer");
    tx_start <= 1'b1;
    @(posedge pclk);
    tx_start <= 1'b0;
    @(posedge pclk);
    chk("transmit", 32'h20000003, dma_req.addr);
    chk("transmit flags", 32'h1, {30'h0, dma_req.to_ram, dma_req_valid});
    rx_start <= 1'b1;
    @(posedge pclk);
    rx_start <= 1'b0;
    @(posedge pclk);
    chk("receive flags", 32'h3, {30'h0, dma_req.to_ram, dma_req_valid});
    pkt(s2);
    chk("receive flags", 32'h0, {31'h0, dma_req_valid});
    wr(12'h600, 32'h3);
    $display("test transfer done");
    dfe_go();
    hi = 0;
    sp = 0;
    // Count at falling edges, where the run outputs have settled
    repeat (200)
    begin
      @(negedge pclk);
      hi += int'(antenna_switch_en);
      sp += int'(sampler_en);
    end
    @(posedge pclk);
    chk("run cycles", 32'h3e, hi);
    chk("sampling cycles", 32'h30, sp);
    rd(12'h458, 32'h0, "run state");
    rd(12'h600, 32'h4, "event status");
    wr(12'h604, 32'h4);
    chk("irq", 32'h1, {31'h0, irq});
    wr(12'h600, 32'h4);
    chk("irq", 32'h0, {31'h0, irq});
    dfe_go();
    for (int n = 0; n < 40 && sampler_en !== 1'b1; n++) @(posedge pclk);
    rd(12'h458, 32'h13, "run state");
    $display("test run done");
    wr(12'h700, 32'h5);
    chk("unmapped error", 32'h1, {31'h0, err_seen});
    rd(12'h700, 32'h0, "unmapped");
    chk("unmapped error", 32'h1, {31'h0, err_seen});
    rd(12'h508, 32'h164, "channel");
    chk("mapped error", 32'h0, {31'h0, err_seen});
    $display("test unmapped done");
    close_out();
  end
endmodule
bind rrs_top rrs_checker rrs_checker_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
  .tx_start(tx_start), .rx_start(rx_start), .rx_done(rx_done), .dma_req(dma_req),
  .dma_req_valid(dma_req_valid), .rf_freq_mhz(rf_freq_mhz),
  .antenna_switch_en(antenna_switch_en), .sampler_en(sampler_en), .dfe_start(dfe_start));
